// ===== design/rcg_regs.sv
/*
 * rcg_regs: serial port configuration, user version tag and reference R
 * divider registers of the clock generator, with a serial slave port.
 * Assumes the host drives sclk, cs_n and sdio slowly against sys_clk
 * (sclk period at least 8 sys_clk cycles) and keeps sclk low while idle.
 */
// Notes on behaviour
// - Direction bit 0: reads on the data pin, out pin floats; 1: on out pin.
// - In I2C mode the direction and bit-order bits are ignored.
// - Order bit 0: MSB first, address falls; 1: LSB first, address rises.
// - Soft reset puts every register at its default, then clears itself.
// - Readback select 0 returns active buffered values, 1 returns pending.
// - Buffered values reach internal logic only on the next update strobe.
// - A 16-bit version tag, low byte first, resets to 0 and drives nothing.
// - First divider: 10 bits, low byte, then bits 9:8 in bits 1:0 of next.
// - Each divider divides by 1 to 1023; zero and one both divide by 1.
// - The second divider is 10 bits, split the same way as the first.
// - Second reference uses its own divider only with the independence bit.
`timescale 1ns/10ps
`default_nettype none

module rcg_regs import rcg_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	output logic serial_out_pin,
	output logic serial_out_pin_oe_n,
	input wire logic io_update,
	input wire logic i2c_mode,
	input wire logic first_reference,
	input wire logic second_reference,
	output logic first_ref_tick,
	output logic second_ref_tick
);

	// ==========================================================
	// pin sampling and edges
	rcg_pins_t raw;
	rcg_pins_t pin;
	rcg_pins_t pin_d;

	assign raw = {sclk, cs_n, sdio_in, io_update, i2c_mode,
		first_reference, second_reference};

	rcg_sync #(.W($bits(rcg_pins_t))) u_sync (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.d_in(raw), .q_out(pin)
	);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			pin_d <= '0;
		else
			pin_d <= pin;
	end

	wire sclk_rise = pin.sclk & !pin_d.sclk;
	wire sclk_fall = !pin.sclk & pin_d.sclk;
	wire cs_on = !pin.cs_n;
	wire cs_fall = cs_on & pin_d.cs_n;
	wire upd_edge = pin.io_update & !pin_d.io_update;
	wire first_edge = pin.first_ref & !pin_d.first_ref;
	wire second_edge = pin.second_ref & !pin_d.second_ref;

	// ==========================================================
	// register state
	rcg_port_cfg_t cfg;
	logic soft_rst;
	logic rb_sel;
	logic [7:0] ver_lo;
	logic [7:0] ver_hi;
	rcg_div_cfg_t buf_cfg;
	rcg_div_cfg_t act_cfg;

	wire dir_eff = cfg.dir & !pin.i2c_mode;
	wire lsb_eff = cfg.lsb_first & !pin.i2c_mode;

	// ==========================================================
	// serial engine
	rcg_spi_state_t state;
	logic [3:0] bit_cnt;
	logic [15:0] sh;
	logic [ADDR_W-1:0] addr;
	logic rd_op;
	logic load_tx;
	logic [7:0] tx;

	// both orders leave the instruction in the same layout
	wire [15:0] next_sh = lsb_eff ? {pin.sdio, sh[15:1]} :
		{sh[14:0], pin.sdio};
	wire in_instr = state == SP_INSTR;
	wire in_data = state == SP_DATA;
	wire instr_done = sclk_rise & in_instr & bit_cnt == INSTR_LAST;
	wire byte_done = sclk_rise & in_data & bit_cnt == BYTE_LAST;
	wire wr_now = byte_done & !rd_op;
	wire [7:0] wr_byte = lsb_eff ? next_sh[15:8] : next_sh[7:0];
	wire [ADDR_W-1:0] step_addr = lsb_eff ? addr + 13'h0001 :
		addr - 13'h0001;
	wire drive = cs_on & in_data & rd_op;
	wire [2:0] tx_idx = lsb_eff ? bit_cnt[2:0] : 3'h7 - bit_cnt[2:0];
	wire tx_bit = tx[tx_idx];

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= SP_IDLE;
			bit_cnt <= 4'h0;
		end else if (!cs_on) begin
			state <= SP_IDLE;
		end else if (cs_fall) begin
			state <= SP_INSTR;
			bit_cnt <= 4'h0;
		end else if (sclk_rise) begin
			case (state)
			SP_INSTR: begin
				if (instr_done)
					state <= SP_DATA;
				bit_cnt <= instr_done ? 4'h0 : bit_cnt + 4'h1;
			end
			SP_DATA: bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
			default: bit_cnt <= 4'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sh <= 16'h0000;
			addr <= '0;
			rd_op <= 1'b0;
			load_tx <= 1'b0;
		end else begin
			load_tx <= instr_done | byte_done;
			if (sclk_rise && (in_instr || in_data))
				sh <= next_sh;
			if (instr_done) begin
				addr <= next_sh[ADDR_W-1:0];
				rd_op <= next_sh[INSTR_RD_BIT];
			end else if (byte_done) begin
				addr <= step_addr;
			end
		end
	end

	// ==========================================================
	// readback
	wire [DIV_W-1:0] rb_div1 = rb_sel ? buf_cfg.div1 : act_cfg.div1;
	wire [DIV_W-1:0] rb_div2 = rb_sel ? buf_cfg.div2 : act_cfg.div2;
	wire rb_indep = rb_sel ? buf_cfg.indep : act_cfg.indep;
	// mirror nibble reads as the reversed upper nibble; soft reset reads 0
	wire [7:0] cfg_rd = {cfg.dir, cfg.lsb_first, 4'h0, cfg.lsb_first,
		cfg.dir};
	wire [7:0] rd_byte =
		(addr == ADDR_CFG) ? cfg_rd :
		(addr == ADDR_RBSEL) ? {7'h00, rb_sel} :
		(addr == ADDR_VER_LO) ? ver_lo :
		(addr == ADDR_VER_HI) ? ver_hi :
		(addr == ADDR_DIV1_LO) ? rb_div1[7:0] :
		(addr == ADDR_DIV1_HI) ? {6'h00, rb_div1[9:8]} :
		(addr == ADDR_DIV2_LO) ? rb_div2[7:0] :
		(addr == ADDR_DIV2_HI) ? {6'h00, rb_div2[9:8]} :
		(addr == ADDR_REF_CTRL) ? {rb_indep, 7'h00} : 8'h00;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx <= 8'h00;
			sdio_out <= 1'b0;
			serial_out_pin <= 1'b0;
			sdio_oe_n <= 1'b1;
			serial_out_pin_oe_n <= 1'b1;
		end else begin
			if (load_tx)
				tx <= rd_byte;
			if (sclk_fall && drive) begin
				sdio_out <= tx_bit;
				serial_out_pin <= tx_bit;
			end
			sdio_oe_n <= !(drive & !dir_eff);
			serial_out_pin_oe_n <= !(drive & dir_eff);
		end
	end

	// ==========================================================
	// register writes
	wire we_cfg = wr_now & addr == ADDR_CFG;
	wire we_rbsel = wr_now & addr == ADDR_RBSEL;
	wire we_ver_lo = wr_now & addr == ADDR_VER_LO;
	wire we_ver_hi = wr_now & addr == ADDR_VER_HI;
	wire we_div1_lo = wr_now & addr == ADDR_DIV1_LO;
	wire we_div1_hi = wr_now & addr == ADDR_DIV1_HI;
	wire we_div2_lo = wr_now & addr == ADDR_DIV2_LO;
	wire we_div2_hi = wr_now & addr == ADDR_DIV2_HI;
	wire we_ref_ctrl = wr_now & addr == ADDR_REF_CTRL;

	// the mirror nibble is not checked; the upper nibble is what counts
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= CFG_RST;
			soft_rst <= 1'b0;
			rb_sel <= RBSEL_RST;
			ver_lo <= VER_RST;
			ver_hi <= VER_RST;
		end else if (soft_rst) begin
			cfg <= CFG_RST;
			soft_rst <= 1'b0;
			rb_sel <= RBSEL_RST;
			ver_lo <= VER_RST;
			ver_hi <= VER_RST;
		end else begin
			if (we_cfg)
				cfg <= {wr_byte[CFG_DIR_BIT], wr_byte[CFG_LSB_BIT]};
			soft_rst <= we_cfg & wr_byte[CFG_SRST_BIT];
			if (we_rbsel)
				rb_sel <= wr_byte[RBSEL_BIT];
			if (we_ver_lo)
				ver_lo <= wr_byte;
			if (we_ver_hi)
				ver_hi <= wr_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			buf_cfg <= DIV_RST;
		end else if (soft_rst) begin
			buf_cfg <= DIV_RST;
		end else begin
			if (we_div1_lo)
				buf_cfg.div1[7:0] <= wr_byte;
			if (we_div1_hi)
				buf_cfg.div1[9:8] <= wr_byte[1:0];
			if (we_div2_lo)
				buf_cfg.div2[7:0] <= wr_byte;
			if (we_div2_hi)
				buf_cfg.div2[9:8] <= wr_byte[1:0];
			if (we_ref_ctrl)
				buf_cfg.indep <= wr_byte[REF_INDEP_BIT];
		end
	end

	// a write and a strobe in one cycle apply the older buffer value
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			act_cfg <= DIV_RST;
		else if (soft_rst)
			act_cfg <= DIV_RST;
		else if (upd_edge)
			act_cfg <= buf_cfg;
	end

	// ==========================================================
	// reference dividers
	wire [DIV_W-1:0] div2_use = act_cfg.indep ? act_cfg.div2 :
		act_cfg.div1;

	rcg_ref_div u_div1 (
		.sys_clk(sys_clk), .reset_n(reset_n), .ref_edge(first_edge),
		.divisor(act_cfg.div1), .tick(first_ref_tick)
	);

	rcg_ref_div u_div2 (
		.sys_clk(sys_clk), .reset_n(reset_n), .ref_edge(second_edge),
		.divisor(div2_use), .tick(second_ref_tick)
	);

	// ==========================================================
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_sdo_hiz;
		!dir_eff |=> serial_out_pin_oe_n;
	endproperty
	a_sdo_hiz: assert property (p_sdo_hiz) else $error("sdo driven");
	property p_sdo_read;
		(drive && dir_eff) |=> !serial_out_pin_oe_n && sdio_oe_n;
	endproperty
	a_sdo_read: assert property (p_sdo_read) else $error("wrong pin");
	property p_i2c_quiet;
		pin.i2c_mode |=> serial_out_pin_oe_n;
	endproperty
	a_i2c_quiet: assert property (p_i2c_quiet) else $error("i2c sdo");
	property p_addr_up;
		(byte_done && lsb_eff) |=> addr == $past(addr) + 13'h0001;
	endproperty
	a_addr_up: assert property (p_addr_up) else $error("no increment");
	property p_addr_down;
		(byte_done && !lsb_eff) |=> addr == $past(addr) - 13'h0001;
	endproperty
	a_addr_down: assert property (p_addr_down) else $error("no decr");
	sequence s_soft_done;
		soft_rst ##1 (!soft_rst && cfg == CFG_RST && act_cfg == DIV_RST &&
			ver_lo == VER_RST && ver_hi == VER_RST);
	endsequence
	property p_soft;
		(we_cfg && wr_byte[CFG_SRST_BIT]) |=> s_soft_done;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset failed");
	property p_rb_active;
		(load_tx && addr == ADDR_DIV1_LO && !rb_sel) |=>
			tx == $past(act_cfg.div1[7:0]);
	endproperty
	a_rb_active: assert property (p_rb_active) else $error("rb src");
	property p_hold;
		(!upd_edge && !soft_rst) |=> $stable(act_cfg);
	endproperty
	a_hold: assert property (p_hold) else $error("early apply");
	property p_apply;
		(upd_edge && !soft_rst) |=> act_cfg == $past(buf_cfg);
	endproperty
	a_apply: assert property (p_apply) else $error("apply lost");
	property p_div1_hi;
		we_div1_hi |=> buf_cfg.div1[9:8] == $past(wr_byte[1:0]);
	endproperty
	a_div1_hi: assert property (p_div1_hi) else $error("div1 msb");
	property p_div2_hi;
		we_div2_hi |=> buf_cfg.div2[9:8] == $past(wr_byte[1:0]);
	endproperty
	a_div2_hi: assert property (p_div2_hi) else $error("div2 msb");
	property p_shared;
		!act_cfg.indep |-> div2_use == act_cfg.div1;
	endproperty
	a_shared: assert property (p_shared) else $error("not shared");
	property p_resv;
		(load_tx && addr == ADDR_DIV1_HI) |=> tx[7:2] == 6'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved set");
endmodule

`default_nettype wire

// ===== design/rcg_pkg.sv
/*
 * rcg_pkg: shared constants and types for the clock generator's serial
 * configuration and reference divider register bank.
 * Assumes a single 100 MHz system clock samples every serial pin.
 */
package rcg_pkg;

	// ==========================================================
	// register addresses (13-bit serial address space)
	localparam int ADDR_W = 13;
	localparam logic [12:0] ADDR_CFG = 13'h000;
	localparam logic [12:0] ADDR_RBSEL = 13'h004;
	localparam logic [12:0] ADDR_VER_LO = 13'h005;
	localparam logic [12:0] ADDR_VER_HI = 13'h006;
	localparam logic [12:0] ADDR_DIV1_LO = 13'h010;
	localparam logic [12:0] ADDR_DIV1_HI = 13'h011;
	localparam logic [12:0] ADDR_DIV2_LO = 13'h012;
	localparam logic [12:0] ADDR_DIV2_HI = 13'h013;
	localparam logic [12:0] ADDR_REF_CTRL = 13'h01c;

	// ==========================================================
	// field positions
	localparam int CFG_DIR_BIT = 7;
	localparam int CFG_LSB_BIT = 6;
	localparam int CFG_SRST_BIT = 5;
	localparam int RBSEL_BIT = 0;
	localparam int REF_INDEP_BIT = 7;
	localparam int DIV_W = 10;
	localparam int INSTR_RD_BIT = 15;
	localparam logic [3:0] INSTR_LAST = 4'hf;
	localparam logic [3:0] BYTE_LAST = 4'h7;

	// ==========================================================
	// types
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdio;
		logic io_update;
		logic i2c_mode;
		logic first_ref;
		logic second_ref;
	} rcg_pins_t;

	typedef struct packed {
		logic dir;
		logic lsb_first;
	} rcg_port_cfg_t;

	typedef struct packed {
		logic indep;
		logic [DIV_W-1:0] div2;
		logic [DIV_W-1:0] div1;
	} rcg_div_cfg_t;

	typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA} rcg_spi_state_t;

	// ==========================================================
	// reset values
	localparam rcg_port_cfg_t CFG_RST = '{dir: 1'b0, lsb_first: 1'b0};
	localparam logic RBSEL_RST = 1'b0;
	localparam logic [7:0] VER_RST = 8'h00;
	localparam rcg_div_cfg_t DIV_RST = '{indep: 1'b0, div2: 10'h000,
		div1: 10'h000};

	// ==========================================================
	// zero and one both mean divide-by-1
	function automatic logic [DIV_W-1:0] rcg_eff_div(
		input logic [DIV_W-1:0] d);
		return (d < 10'h002) ? 10'h001 : d;
	endfunction

endpackage

// ===== design/rcg_sync.sv
/*
 * rcg_sync: two flip-flop synchroniser for a bundle of pin levels.
 * Assumes each bit is an independent slow level; bundles are not coherent.
 */
`timescale 1ns/10ps
`default_nettype none

module rcg_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	// ==========================================================
	// first stage is read only by the second
	logic [W-1:0] meta;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= '0;
			q_out <= '0;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end

endmodule

`default_nettype wire

// ===== design/rcg_ref_div.sv
/*
 * rcg_ref_div: reference R divider, one tick per N reference edges.
 * Assumes ref_edge is a one-cycle pulse already in the sys_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none

module rcg_ref_div import rcg_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic ref_edge,
	input wire logic [DIV_W-1:0] divisor,
	output logic tick
);

	// ==========================================================
	// counter
	logic [DIV_W-1:0] cnt;
	wire [DIV_W-1:0] last = rcg_eff_div(divisor) - 10'h001;
	// >= so a divisor lowered mid-count wraps on the next reference edge instead of rolling over
	wire wrap = cnt >= last;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= ref_edge & wrap;
			if (ref_edge)
				cnt <= wrap ? '0 : cnt + 10'h001;
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_div_wrap;
		(ref_edge && cnt == last) |=> tick && cnt == 10'h000;
	endproperty
	a_div_wrap: assert property (p_div_wrap) else $error("no wrap tick");

	property p_div_count;
		(ref_edge && cnt < last) |=> !tick && cnt == $past(cnt) + 10'h001;
	endproperty
	a_div_count: assert property (p_div_count) else $error("bad count");

endmodule

`default_nettype wire

// ===== tb/rcg_host_model.sv
/*
 * rcg_host_model: behavioural serial host for the register bank.
 * Assumes the bench resolves the data pin and calls xfer between frames.
 */
`timescale 1ns/10ps
`default_nettype none

module rcg_host_model (
	input wire logic sys_clk,
	input wire logic sdio_wire,
	input wire logic out_wire,
	output logic sclk,
	output logic cs_n,
	output logic host_sdio
);
	// sclk stands low between frames, half period of 8 sys_clk cycles
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_sdio = 1'b0;
	end

	// ==========================================================
	// one bit: data set while sclk low, sampled as sclk rises
	task automatic bit_io(input logic b, input logic use_out,
		output logic r);
		host_sdio = b;
		repeat (8) @(negedge sys_clk);
		sclk = 1'b1;
		r = use_out ? out_wire : sdio_wire;
		repeat (8) @(negedge sys_clk);
		sclk = 1'b0;
	endtask

	// ==========================================================
	// one frame: instruction then n bytes, byte j in wd[8j+7:8j]
	task automatic xfer(input logic rd, input logic [12:0] addr,
		input logic lsb, input logic use_out, input int n,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [15:0] ins;
		logic r;
		int i;
		int k;
		ins = {rd, 2'b00, addr};
		rdat = 16'h0000;
		cs_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		for (i = 0; i < 16; i++)
			bit_io(ins[lsb ? i : 15 - i], 1'b0, r);
		for (i = 0; i < 8 * n; i++) begin
			k = (i / 8) * 8 + (lsb ? i % 8 : 7 - i % 8);
			// released line shows the inverse of its last value
			bit_io(rd ? ~host_sdio : wd[k], use_out, r);
			rdat[k] = r;
		end
		repeat (8) @(negedge sys_clk);
		cs_n = 1'b1;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
/*
 * tb: self-checking bench for rcg_regs over its serial port.
 * Assumes rcg_host_model as the host and a 100 MHz sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module tb import rcg_pkg::*; ;
	logic sys_clk, reset_n, io_update, i2c_mode;
	logic first_reference, second_reference;
	logic sclk, cs_n, host_sdio, sdio_wire, out_wire;
	logic sdio_out, sdio_oe_n, serial_out_pin, serial_out_pin_oe_n;
	logic first_ref_tick, second_ref_tick;
	logic mode_lsb, mode_out, saw_sdio, saw_out;
	logic [15:0] rd_val;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	int n1, n2;
	logic [12:0] rst_addr [8] = '{ADDR_CFG, ADDR_RBSEL, ADDR_VER_LO,
		ADDR_VER_HI, ADDR_DIV1_LO, ADDR_DIV1_HI, ADDR_DIV2_LO, ADDR_DIV2_HI};

	assign sdio_wire = sdio_oe_n ? host_sdio : sdio_out;
	assign out_wire = serial_out_pin_oe_n ? ~serial_out_pin : serial_out_pin;

	rcg_regs dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
		.sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.serial_out_pin(serial_out_pin),
		.serial_out_pin_oe_n(serial_out_pin_oe_n),
		.io_update(io_update), .i2c_mode(i2c_mode),
		.first_reference(first_reference),
		.second_reference(second_reference),
		.first_ref_tick(first_ref_tick), .second_ref_tick(second_ref_tick)
	);

	rcg_host_model host (
		.sys_clk(sys_clk), .sdio_wire(sdio_wire), .out_wire(out_wire),
		.sclk(sclk), .cs_n(cs_n), .host_sdio(host_sdio)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// monitors and timeout
	always @(negedge sys_clk) begin
		cycles++;
		if (first_ref_tick === 1'b1)
			n1++;
		if (second_ref_tick === 1'b1)
			n2++;
		if (sdio_oe_n === 1'b0)
			saw_sdio = 1'b1;
		if (serial_out_pin_oe_n === 1'b0)
			saw_out = 1'b1;
		// the whole run needs about 28000 cycles
		if (cycles == 60000) begin
			mismatches++;
			print_verdict();
		end
	end

	// ==========================================================
	// tasks
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, mode_lsb, 1'b0, 1, {8'h00, d}, rd_val);
	endtask

	task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
		saw_sdio = 1'b0;
		saw_out = 1'b0;
		host.xfer(1'b1, a, mode_lsb, mode_out, 1, 16'h0000, rd_val);
		check(rd_val, {8'h00, e});
	endtask

	task automatic apply_update();
		io_update = 1'b1;
		repeat (4) @(negedge sys_clk);
		io_update = 1'b0;
		repeat (8) @(negedge sys_clk);
	endtask

	task automatic pulse_refs(input int n, input int e1, input int e2);
		n1 = 0;
		n2 = 0;
		repeat (n) begin
			first_reference = 1'b1;
			second_reference = 1'b1;
			repeat (4) @(negedge sys_clk);
			first_reference = 1'b0;
			second_reference = 1'b0;
			repeat (4) @(negedge sys_clk);
		end
		repeat (8) @(negedge sys_clk);
		check(n1[15:0], e1[15:0]);
		check(n2[15:0], e2[15:0]);
	endtask

	// low nibble is the bit-reversed high nibble
	function automatic logic [7:0] cfg_byte(input logic [3:0] h);
		return {h, h[0], h[1], h[2], h[3]};
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		io_update = 1'b0;
		i2c_mode = 1'b0;
		first_reference = 1'b0;
		second_reference = 1'b0;
		mode_lsb = 1'b0;
		mode_out = 1'b0;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		foreach (rst_addr[i])
			rdchk(rst_addr[i], 8'h00);
		wr(ADDR_VER_LO, 8'ha5);
		wr(ADDR_VER_HI, 8'h3c);
		rdchk(ADDR_VER_LO, 8'ha5);
		check({15'h0000, saw_sdio}, 16'h0001);
		check({15'h0000, saw_out}, 16'h0000);
		rdchk(ADDR_VER_HI, 8'h3c);
		wr(13'h020, 8'hff);
		rdchk(13'h020, 8'h00);
		// buffered divider: pending until the update strobe
		wr(ADDR_DIV1_LO, 8'h05);
		wr(ADDR_DIV1_HI, 8'hfc);
		rdchk(ADDR_DIV1_LO, 8'h00);
		wr(ADDR_RBSEL, 8'h01);
		rdchk(ADDR_DIV1_LO, 8'h05);
		rdchk(ADDR_DIV1_HI, 8'h00);
		pulse_refs(20, 20, 20);
		apply_update();
		wr(ADDR_RBSEL, 8'h00);
		rdchk(ADDR_DIV1_LO, 8'h05);
		pulse_refs(20, 4, 4);
		wr(ADDR_DIV2_LO, 8'h03);
		wr(ADDR_REF_CTRL, 8'h80);
		pulse_refs(10, 2, 2);
		apply_update();
		pulse_refs(15, 3, 5);
		wr(ADDR_DIV1_LO, 8'hff);
		wr(ADDR_DIV1_HI, 8'h03);
		apply_update();
		pulse_refs(1022, 0, 340);
		pulse_refs(1, 1, 1);
		// upper bits of the second divider, left pending
		wr(ADDR_DIV2_HI, 8'hfd);
		wr(ADDR_RBSEL, 8'h01);
		rdchk(ADDR_DIV2_HI, 8'h01);
		wr(ADDR_RBSEL, 8'h00);
		rdchk(ADDR_DIV2_HI, 8'h00);
		rdchk(ADDR_REF_CTRL, 8'h80);
		// bit order and address stepping
		wr(ADDR_CFG, cfg_byte(4'h4));
		mode_lsb = 1'b1;
		rdchk(ADDR_CFG, 8'h42);
		host.xfer(1'b0, ADDR_VER_LO, 1'b1, 1'b0, 2, 16'h2211, rd_val);
		rdchk(ADDR_VER_HI, 8'h22);
		rdchk(ADDR_VER_LO, 8'h11);
		wr(ADDR_CFG, cfg_byte(4'h8));
		mode_lsb = 1'b0;
		mode_out = 1'b1;
		rdchk(ADDR_VER_LO, 8'h11);
		check({15'h0000, saw_out}, 16'h0001);
		check({15'h0000, saw_sdio}, 16'h0000);
		host.xfer(1'b0, ADDR_VER_HI, 1'b0, 1'b0, 2, 16'h4433, rd_val);
		rdchk(ADDR_VER_LO, 8'h44);
		// strap forces the data pin and msb-first order
		wr(ADDR_CFG, cfg_byte(4'hc));
		i2c_mode = 1'b1;
		mode_out = 1'b0;
		rdchk(ADDR_VER_HI, 8'h33);
		check({15'h0000, saw_out}, 16'h0000);
		i2c_mode = 1'b0;
		mode_lsb = 1'b1;
		mode_out = 1'b1;
		// soft reset; 0x24 is the same in either bit order
		wr(ADDR_CFG, cfg_byte(4'h2));
		mode_lsb = 1'b0;
		mode_out = 1'b0;
		rdchk(ADDR_CFG, 8'h00);
		rdchk(ADDR_VER_LO, 8'h00);
		rdchk(ADDR_DIV1_LO, 8'h00);
		print_verdict();
	end
endmodule

`default_nettype wire
